// >>> pss_pkg.sv
`default_nettype none
package pss_pkg;
	// ---------------------------------------------
	// timing
	// ---------------------------------------------
	localparam int unsigned CLK_MHZ      = 100;
	localparam int unsigned SLOT_MIN_US  = 32;
	localparam int unsigned SLOT_MIN_CYC = SLOT_MIN_US * CLK_MHZ;
	localparam logic [3:0]  SLOT_MAX_SEL = 4'h8;
	localparam logic [3:0]  SLOT_SEL_RST = 4'h2;
	localparam int unsigned NSTEP        = 16;
	localparam int unsigned NREG_DEF     = 8;
	localparam int unsigned FIRST_LINREG = 4;

	// ---------------------------------------------
	// register map
	// ---------------------------------------------
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_PTR    = 8'h04;
	localparam logic [7:0]  OFS_TIME   = 8'h08;
	localparam logic [7:0]  OFS_STAT   = 8'h0c;
	localparam logic [7:0]  OFS_AUX    = 8'h10;
	localparam logic [7:0]  OFS_REG    = 8'h20;
	localparam int unsigned C_GO1      = 0;
	localparam int unsigned C_GO2      = 1;
	localparam int unsigned C_GO3      = 2;
	localparam int unsigned C_PART     = 3;
	localparam int unsigned C_DEF      = 4;
	localparam int unsigned C_NVM      = 5;
	localparam int unsigned C_FSD      = 6;
	localparam int unsigned C_HSD      = 7;
	localparam int unsigned PF_FIRST   = 0;
	localparam int unsigned PF_SECOND  = 4;
	localparam int unsigned PF_FINAL   = 8;
	localparam int unsigned PF_PART    = 12;
	localparam int unsigned TF_NORM    = 0;
	localparam int unsigned TF_EMPTY   = 4;
	localparam int unsigned RC_AUTO    = 4;
	localparam int unsigned RC_KEEP    = 5;
	localparam int unsigned STAT_MODE  = 4;
	localparam int unsigned STAT_SEQ   = 6;
	localparam int unsigned STAT_IRQ   = 8;
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [15:0] PTR_RST    = 16'h0f73;
	localparam logic [3:0]  AUX_RST    = 4'h0;
	localparam logic [5:0]  REGCFG_RST = 6'h00;

	// ---------------------------------------------
	// states
	// ---------------------------------------------
	typedef enum logic [1:0] {
		M_RESET  = 2'b00,
		M_PDOWN  = 2'b01,
		M_SYSTEM = 2'b10,
		M_ACTIVE = 2'b11
	} pss_mode_t;

	typedef enum logic [1:0] {
		SQ_IDLE   = 2'b00,
		SQ_RELOAD = 2'b01,
		SQ_ARMED  = 2'b10,
		SQ_RUN    = 2'b11
	} pss_seq_t;
endpackage
`default_nettype wire

// >>> pss_slot_timer.sv
`default_nettype none
module pss_slot_timer import pss_pkg::*; #(
	parameter int unsigned BASE_CYC = SLOT_MIN_CYC
) (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       run,
	input  wire logic [3:0] sel,
	output logic            done_q
);
	localparam int unsigned CW = $clog2(BASE_CYC << SLOT_MAX_SEL) + 1;

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] lim;
	logic [CW-1:0] gap_q;
	logic [3:0]    s;

	// ---------------------------------------------
	// slot length
	// ---------------------------------------------
	// codes above the top one clamp, so a slot never exceeds the longest
	always_comb begin
		s   = (sel > SLOT_MAX_SEL) ? SLOT_MAX_SEL : sel;
		lim = CW'(BASE_CYC) << s; // see R6
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else if (!run) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else if (cnt_q >= lim - CW'(1)) begin
			cnt_q  <= '0;
			done_q <= 1'b1; // see R1
		end else begin
			cnt_q  <= cnt_q + CW'(1);
			done_q <= 1'b0;
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			gap_q <= '0;
		end else if (!run || done_q) begin
			gap_q <= '0;
		end else begin
			gap_q <= gap_q + CW'(1);
		end
	end

	property p_slot_min;
		@(posedge mclk) disable iff (reset)
		done_q |-> gap_q + CW'(1) >= CW'(BASE_CYC);
	endproperty
	a_slot_min: assert property (p_slot_min) else $error("slot shorter than base time"); // see R6
endmodule
`default_nettype wire

// >>> pss_seq_top.sv
`default_nettype none
// Operation
// R1: sixteen steps, each slot 32 us up to 8.192 ms long.
// R2: reaching final pointer on power-up stops stepping and raises host interrupt.
// R3: power-down replays the one power-up configuration in reverse order.
// R4: functions pointing above final pointer are ignored by stepping.
// R5: only regulators may use step 0; other functions at 0 are disabled.
// R6: normal slot delay from its field, default 128 us, 32 us to 8 ms.
// R7: slots with no function use the separate empty-slot delay.
// R8: both delays reload from nvm at each power-up start; also for slot 0.
// R9: after trigger, optional partial nvm reload, then start on first go.
// R10: first phase runs 0 to first end, then waits for second go.
// R11: second phase runs to second end; with watchdog active enter ACTIVE.
// R12: host writes third go; device steps on up to final pointer.
// R13: final pointer below phase ends disables all later steps.
// R14: clearing second go reverses to first end; first go reverses to 0.
// R15: watchdog power-down returns to step 0 at once.
// R16: partial-off stops down at partial pointer; next power-up starts there.
// R17: shutdown is a power-down, then proceeds from POWERDOWN into RESET.
// R18: regulator on at its step going up, off there going down.
// R19: up: auto and keep clear ends off, else on with A setting.
// R20: down: keep clear turns off with A; keep set stays on with B.
// R21: step0 default set enables step-0 regulators on entering POWERDOWN.
// R22: with nvm presets, first linear regulator stays on in RESET only; the code leaves it on when RESET ends.
// R23: after reset step 0, nothing starts before trigger and go.
module pss_seq_top import pss_pkg::*; #(
	parameter int unsigned SLOT_BASE_CYC = SLOT_MIN_CYC,
	parameter int unsigned NREG          = NREG_DEF
) (
	input  wire logic            mclk,
	input  wire logic            reset,
	input  wire logic [7:0]      avs_address,
	input  wire logic            avs_read,
	input  wire logic            avs_write,
	input  wire logic [31:0]     avs_writedata,
	output logic      [31:0]     avs_readdata,
	output logic                 avs_waitrequest,
	input  wire logic            power_up_trig,
	input  wire logic            wdog_timeout,
	input  wire logic            wdog_active,
	input  wire logic            shutdown_req,
	input  wire logic            fault_shutdown,
	input  wire logic            first_phase_go_pin,
	input  wire logic            second_phase_go_pin,
	input  wire logic            ext_reset_req_n,
	input  wire logic [3:0]      nvm_slot_delay_sel,
	input  wire logic [3:0]      nvm_empty_slot_delay_sel,
	input  wire logic            nvm_first_go,
	input  wire logic            nvm_second_go,
	input  wire logic            nvm_step0_default_on,
	input  wire logic            nvm_first_linreg_keep_on,
	input  wire logic            nvm_first_linreg_on,
	input  wire logic            nvm_reload_done,
	output logic                 partial_nvm_reload,
	output logic      [NREG-1:0] reg_en_q,
	output logic      [NREG-1:0] reg_sel_b_q,
	output logic                 aux_on_q,
	output pss_mode_t            mode_q,
	output logic      [3:0]      step_q,
	output logic                 irq_out_n
);
	// ---------------------------------------------
	// declarations
	// ---------------------------------------------
	logic [2:0]  pin_s1_q;
	logic [2:0]  pin_s2_q;
	logic        rst_s3_q;
	logic [7:0]  ctrl_q;
	logic [15:0] ptr_q;
	logic [7:0]  slot_timing_reg_q;
	logic [3:0]  aux_ptr_q;
	logic [5:0]  regcfg_q [NREG];
	logic [31:0] rd_data;
	logic        wr_hit;
	pss_seq_t    sq_q;
	logic        sd_q;
	logic [3:0]  fin;
	logic [3:0]  fl;
	logic [3:0]  tgt;
	logic [3:0]  ns;
	logic [3:0]  es;
	logic [3:0]  slot_delay_sel;
	logic [3:0]  empty_slot_delay_sel;
	logic        go1;
	logic        go2;
	logic        up;
	logic        want;
	logic        empty;
	logic        tmr_done;
	logic        rst_fall;
	logic        host_sd;
	logic        sd_ev;
	logic        jump;
	logic        pu_start;
	logic        enter_pd;
	logic        keep1;
	logic        moved;

	function automatic logic hits(input logic [3:0] p, input logic [3:0] s, input logic [3:0] f);
		return (p == s) && (p <= f);
	endfunction

	function automatic logic is_reg(input logic [7:0] a);
		return (a[7:5] == OFS_REG[7:5]) && (a[1:0] == 2'h0) && (32'(a[4:2]) < NREG);
	endfunction

	// ---------------------------------------------
	// pin synchronisers
	// ---------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pin_s1_q <= 3'h4;
			pin_s2_q <= 3'h4;
			rst_s3_q <= 1'b1;
		end else begin
			pin_s1_q <= {ext_reset_req_n, second_phase_go_pin, first_phase_go_pin};
			pin_s2_q <= pin_s1_q;
			rst_s3_q <= pin_s2_q[2];
		end
	end

	assign rst_fall = rst_s3_q && !pin_s2_q[2];
	assign host_sd  = shutdown_req || rst_fall;
	assign sd_ev    = host_sd || fault_shutdown;
	assign go1      = ctrl_q[C_GO1] || pin_s2_q[0];
	assign go2      = ctrl_q[C_GO2] || pin_s2_q[1];
	assign keep1    = nvm_step0_default_on && nvm_first_linreg_keep_on && nvm_first_linreg_on;

	// ---------------------------------------------
	// bus slave
	// ---------------------------------------------
	// one wait cycle per access keeps read data a plain flop
	assign wr_hit = avs_write && !avs_waitrequest;

	always_comb begin
		rd_data = 32'h0;
		case (avs_address)
			OFS_CTRL: rd_data[7:0] = ctrl_q;
			OFS_PTR:  rd_data[15:0] = ptr_q;
			OFS_TIME: rd_data[7:0] = slot_timing_reg_q;
			OFS_AUX:  rd_data[3:0] = aux_ptr_q;
			OFS_STAT: begin
				rd_data[3:0]                  = step_q;
				rd_data[STAT_MODE +: 2]       = mode_q;
				rd_data[STAT_SEQ +: 2]        = sq_q;
				rd_data[STAT_IRQ]             = !irq_out_n;
			end
			default: begin
				if (is_reg(avs_address)) begin
					rd_data[5:0] = regcfg_q[avs_address[4:2]];
				end
			end
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= rd_data;
			end
		end
	end

	// ---------------------------------------------
	// configuration registers
	// ---------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ctrl_q            <= CTRL_RST;
			ptr_q             <= PTR_RST;
			slot_timing_reg_q <= {SLOT_SEL_RST, SLOT_SEL_RST};
			aux_ptr_q         <= AUX_RST;
			for (int i = 0; i < NREG; i++) begin
				regcfg_q[i] <= REGCFG_RST;
			end
		end else begin
			if (wr_hit && avs_address == OFS_CTRL) begin
				ctrl_q <= avs_writedata[7:0];
			end
			if (wr_hit && avs_address == OFS_PTR) begin
				ptr_q <= avs_writedata[15:0];
			end
			if (wr_hit && avs_address == OFS_TIME) begin
				slot_timing_reg_q <= avs_writedata[7:0];
			end
			if (wr_hit && avs_address == OFS_AUX) begin
				aux_ptr_q <= avs_writedata[3:0];
			end
			for (int i = 0; i < NREG; i++) begin
				if (wr_hit && is_reg(avs_address) && 32'(avs_address[4:2]) == i) begin
					regcfg_q[i] <= avs_writedata[5:0];
				end
			end
			if (pu_start) begin
				slot_timing_reg_q[TF_NORM +: 4]  <= nvm_slot_delay_sel; // see R8
				slot_timing_reg_q[TF_EMPTY +: 4] <= nvm_empty_slot_delay_sel; // see R8
				ctrl_q[C_GO1]                    <= nvm_first_go; // see R9
				ctrl_q[C_GO2]                    <= nvm_second_go; // see R10
			end
			// hardware drop of the go bits outranks a simultaneous write
			if (wdog_timeout || sd_ev) begin
				ctrl_q[C_GO3:C_GO1] <= 3'h0;
			end
		end
	end

	// ---------------------------------------------
	// step target and slot timing
	// ---------------------------------------------
	assign fin = ptr_q[PF_FINAL +: 4];

	always_comb begin
		fl = ctrl_q[C_PART] ? ptr_q[PF_PART +: 4] : 4'h0; // see R16
		if (sd_q) begin
			tgt = 4'h0; // see R17
		end else if (!go1) begin
			tgt = fl; // see R14
		end else if (!go2) begin
			tgt = ptr_q[PF_FIRST +: 4]; // see R10 R14
		end else if (!ctrl_q[C_GO3]) begin
			tgt = ptr_q[PF_SECOND +: 4]; // see R11
		end else begin
			tgt = fin; // see R12
		end
		if (tgt > fin) begin
			tgt = fin; // see R2 R13
		end
	end

	assign want = (sq_q == SQ_RUN) && (step_q != tgt);
	assign up   = tgt > step_q;
	assign ns   = up ? step_q + 4'h1 : step_q - 4'h1;
	assign es   = up ? ns : step_q; // see R3
	assign moved = tmr_done && want && !jump;

	always_comb begin
		empty = !(aux_ptr_q != 4'h0 && hits(aux_ptr_q, es, fin));
		for (int i = 0; i < NREG; i++) begin
			if (hits(regcfg_q[i][3:0], es, fin)) begin
				empty = 1'b0;
			end
		end
	end

	assign slot_delay_sel       = slot_timing_reg_q[TF_NORM +: 4];
	assign empty_slot_delay_sel = slot_timing_reg_q[TF_EMPTY +: 4];

	pss_slot_timer #(
		.BASE_CYC (SLOT_BASE_CYC)
	) u_timer (
		.mclk   (mclk),
		.reset  (reset),
		.run    (want),
		.sel    (empty ? empty_slot_delay_sel : slot_delay_sel), // see R7
		.done_q (tmr_done)
	);

	// ---------------------------------------------
	// sequence control
	// ---------------------------------------------
	assign jump = (sq_q != SQ_IDLE || step_q != 4'h0) && mode_q != M_RESET
		&& (wdog_timeout || (fault_shutdown && ctrl_q[C_FSD]) || (host_sd && ctrl_q[C_HSD]));
	assign pu_start = sq_q == SQ_IDLE && mode_q == M_PDOWN && power_up_trig && !sd_q; // see R23
	assign enter_pd = mode_q == M_RESET && pin_s2_q[2] && !sd_q;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sq_q               <= SQ_IDLE;
			partial_nvm_reload <= 1'b0;
		end else begin
			partial_nvm_reload <= (pu_start && ctrl_q[C_NVM]) || (sq_q == SQ_RELOAD && !nvm_reload_done);
			if (jump || (sd_q && sq_q != SQ_RUN)) begin
				sq_q <= SQ_IDLE; // see R15
			end else begin
				case (sq_q)
					SQ_IDLE: begin
						if (pu_start) begin
							sq_q <= ctrl_q[C_NVM] ? SQ_RELOAD : SQ_ARMED; // see R9
						end
					end
					SQ_RELOAD: begin
						if (nvm_reload_done) begin
							sq_q <= SQ_ARMED;
						end
					end
					SQ_ARMED: begin
						if (go1) begin
							sq_q <= SQ_RUN; // see R9
						end
					end
					SQ_RUN: begin
						if ((sd_q || !go1) && step_q == tgt) begin
							sq_q <= SQ_IDLE;
						end
					end
					default: sq_q <= SQ_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			step_q <= 4'h0; // see R23
		end else if (jump) begin
			step_q <= 4'h0; // see R15
		end else if (moved) begin
			step_q <= ns; // see R1
		end
	end

	// shutdown request sets the flag outside RESET only; in RESET the flag clears
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sd_q <= 1'b0;
		end else if (sd_ev && mode_q != M_RESET) begin
			sd_q <= 1'b1; // see R17
		end else if (mode_q == M_RESET) begin
			sd_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			mode_q <= M_RESET;
		end else begin
			case (mode_q)
				M_RESET: begin
					if (enter_pd) begin
						mode_q <= M_PDOWN;
					end
				end
				M_PDOWN: begin
					if (sd_q && sq_q == SQ_IDLE) begin
						mode_q <= M_RESET; // see R17
					end else if (pu_start) begin
						mode_q <= M_SYSTEM;
					end
				end
				M_SYSTEM: begin
					if (sq_q == SQ_IDLE) begin
						mode_q <= M_PDOWN;
					end else if (sq_q == SQ_RUN && step_q == ptr_q[PF_SECOND +: 4] && wdog_active) begin
						mode_q <= M_ACTIVE; // see R11
					end
				end
				M_ACTIVE: begin
					if (sq_q == SQ_IDLE) begin
						mode_q <= M_PDOWN;
					end else if (step_q < ptr_q[PF_SECOND +: 4]) begin
						mode_q <= M_SYSTEM;
					end
				end
				default: mode_q <= M_RESET;
			endcase
		end
	end

	// ---------------------------------------------
	// regulator and function outputs
	// ---------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			reg_en_q    <= '0;
			reg_sel_b_q <= '0;
			aux_on_q    <= 1'b0;
		end else begin
			for (int i = 0; i < NREG; i++) begin
				if (enter_pd) begin
					if (regcfg_q[i][3:0] == 4'h0 && ctrl_q[C_DEF]) begin
						reg_en_q[i]    <= 1'b1; // see R21
						reg_sel_b_q[i] <= 1'b0;
					end
				end else if (mode_q == M_RESET) begin
					reg_en_q[i]    <= (i == FIRST_LINREG) && keep1; // see R22
					reg_sel_b_q[i] <= 1'b0;
				end else if (jump) begin
					if (regcfg_q[i][3:0] != 4'h0 && regcfg_q[i][3:0] <= fin) begin
						reg_en_q[i]    <= regcfg_q[i][RC_KEEP]; // see R15 R20
						reg_sel_b_q[i] <= regcfg_q[i][RC_KEEP];
					end
				end else if (moved && hits(regcfg_q[i][3:0], es, fin)) begin // see R4 R18
					reg_en_q[i]    <= up ? (regcfg_q[i][RC_AUTO] | regcfg_q[i][RC_KEEP]) // see R19
						: regcfg_q[i][RC_KEEP]; // see R20
					reg_sel_b_q[i] <= !up && regcfg_q[i][RC_KEEP];
				end
			end
			if (mode_q == M_RESET || aux_ptr_q == 4'h0) begin
				aux_on_q <= 1'b0; // see R5
			end else if (jump && aux_ptr_q <= fin) begin
				aux_on_q <= 1'b0;
			end else if (moved && hits(aux_ptr_q, es, fin)) begin
				aux_on_q <= up; // see R4
			end
		end
	end

	// pending until software writes one to the status bit; a new set wins
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			irq_out_n <= 1'b1;
		end else if (moved && up && ns == fin) begin
			irq_out_n <= 1'b0; // see R2
		end else if (wr_hit && avs_address == OFS_STAT && avs_writedata[STAT_IRQ]) begin
			irq_out_n <= 1'b1;
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	property p_final_irq;
		@(posedge mclk) disable iff (reset)
		moved && up && ns == fin |=> !irq_out_n && step_q == $past(fin);
	endproperty
	a_final_irq: assert property (p_final_irq) else $error("final step without interrupt"); // see R2

	property p_one_step;
		@(posedge mclk) disable iff (reset)
		$changed(step_q) && !$past(jump) |-> step_q == $past(step_q) + 4'h1 || step_q == $past(step_q) - 4'h1;
	endproperty
	a_one_step: assert property (p_one_step) else $error("step moved by more than one"); // see R1

	property p_clamp;
		@(posedge mclk) disable iff (reset)
		$changed(step_q) && $past(up) && !$past(jump) |-> step_q <= $past(fin);
	endproperty
	a_clamp: assert property (p_clamp) else $error("step passed final pointer"); // see R13

	property p_wdog;
		@(posedge mclk) disable iff (reset)
		wdog_timeout && mode_q != M_RESET && (sq_q != SQ_IDLE || step_q != 4'h0) |=> step_q == 4'h0 && sq_q == SQ_IDLE;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog did not return to step 0"); // see R15

	property p_armed;
		@(posedge mclk) disable iff (reset)
		sq_q == SQ_ARMED && go1 && !jump && !sd_q |=> sq_q == SQ_RUN;
	endproperty
	a_armed: assert property (p_armed) else $error("first phase did not start"); // see R9

	property p_sd_reset;
		@(posedge mclk) disable iff (reset)
		mode_q == M_PDOWN && sd_q && sq_q == SQ_IDLE |=> mode_q == M_RESET;
	endproperty
	a_sd_reset: assert property (p_sd_reset) else $error("shutdown did not reach reset mode"); // see R17

	property p_reset_keep;
		@(posedge mclk) disable iff (reset)
		mode_q == M_RESET && !enter_pd |=> reg_en_q[FIRST_LINREG] == $past(keep1);
	endproperty
	a_reset_keep: assert property (p_reset_keep) else $error("wrong linear regulator state in reset"); // see R22

	property p_aux0;
		@(posedge mclk) disable iff (reset)
		aux_ptr_q == 4'h0 |=> !aux_on_q;
	endproperty
	a_aux0: assert property (p_aux0) else $error("function at step 0 not disabled"); // see R5

	property p_idle_hold;
		@(posedge mclk) disable iff (reset)
		sq_q == SQ_IDLE && !jump |=> $stable(step_q);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("step moved while idle"); // see R23

	property p_up_on;
		@(posedge mclk) disable iff (reset)
		moved && up && hits(regcfg_q[0][3:0], es, fin)
		|=> reg_en_q[0] == $past(regcfg_q[0][RC_AUTO] | regcfg_q[0][RC_KEEP]) && !reg_sel_b_q[0];
	endproperty
	a_up_on: assert property (p_up_on) else $error("regulator wrong after up step"); // see R19

	property p_dn_keep;
		@(posedge mclk) disable iff (reset)
		moved && !up && hits(regcfg_q[0][3:0], es, fin)
		|=> reg_en_q[0] == $past(regcfg_q[0][RC_KEEP]) && reg_sel_b_q[0] == $past(regcfg_q[0][RC_KEEP]);
	endproperty
	a_dn_keep: assert property (p_dn_keep) else $error("regulator wrong after down step"); // see R20
endmodule
`default_nettype wire

// >>> pss_host_model.sv
`default_nettype none
module pss_host_model (
	input  wire logic mclk,
	input  wire logic want_first,
	input  wire logic want_second,
	output logic      first_phase_go_pin,
	output logic      second_phase_go_pin,
	output logic      ext_reset_req_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------
	// host pins
	// ---------------------------------------------
	// pins move just after an edge, as a synchronous host would
	initial begin
		ext_reset_req_n = 1'b1;
	end
	always @(posedge mclk) begin
		first_phase_go_pin <= want_first;
		second_phase_go_pin <= want_second;
	end
endmodule
`default_nettype wire

// >>> pss_seq_top_tb.sv
`default_nettype none
module pss_seq_top_tb import pss_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------
	// bench
	// ---------------------------------------------
	logic mclk, reset, avs_read, avs_write, avs_waitrequest, power_up_trig, wdog_timeout, wdog_active;
	logic shutdown_req, fault_shutdown, nvm_first_go, nvm_second_go, nvm_step0_default_on;
	logic nvm_first_linreg_keep_on, nvm_first_linreg_on, nvm_reload_done, partial_nvm_reload;
	logic first_phase_go_pin, second_phase_go_pin, ext_reset_req_n, aux_on_q, irq_out_n, wf, wsc;
	logic [7:0] avs_address, reg_en_q, reg_sel_b_q;
	logic [31:0] avs_writedata, avs_readdata, r;
	logic [3:0] nvm_slot_delay_sel, nvm_empty_slot_delay_sel, step_q, hi;
	pss_mode_t mode_q;
	int error_cnt, n_tests, cyc, seed;

	// short base slot keeps the run brief; step waits poll up to cycle limits sized for it
	pss_seq_top #(.SLOT_BASE_CYC(4), .NREG(8)) pss_seq_top_i (.mclk, .reset, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .power_up_trig, .wdog_timeout,
		.wdog_active, .shutdown_req, .fault_shutdown, .first_phase_go_pin, .second_phase_go_pin,
		.ext_reset_req_n, .nvm_slot_delay_sel, .nvm_empty_slot_delay_sel, .nvm_first_go, .nvm_second_go,
		.nvm_step0_default_on, .nvm_first_linreg_keep_on, .nvm_first_linreg_on, .nvm_reload_done,
		.partial_nvm_reload, .reg_en_q, .reg_sel_b_q, .aux_on_q, .mode_q, .step_q, .irq_out_n);
	pss_host_model pss_host_model_i (.mclk, .want_first(wf), .want_second(wsc), .first_phase_go_pin,
		.second_phase_go_pin, .ext_reset_req_n);

	function automatic logic on_up(input logic [3:0] p, input logic a, input logic k, input logic [3:0] s);
		return p != 4'h0 && p <= s && p <= 4'h6 && (a || k);
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wait_step(input logic [3:0] s, input int lim);
		int k;
		k = 0;
		while (step_q !== s && k < lim) begin
			@(posedge mclk);
			k++;
		end
		chk("step", {28'h0, s}, {28'h0, step_q});
	endtask

	task automatic trig();
		@(posedge mclk);
		power_up_trig <= 1'b1;
		@(posedge mclk);
		power_up_trig <= 1'b0;
	endtask

	task automatic print_verdict();
		if (error_cnt == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	initial begin
		seed = 4563;
		{avs_read, avs_write, power_up_trig, wdog_timeout, shutdown_req, fault_shutdown, wf, wsc} = '0;
		nvm_second_go = 1'b0;
		{nvm_step0_default_on, nvm_first_linreg_keep_on, nvm_first_linreg_on} = 3'h7;
		{nvm_reload_done, avs_address, avs_writedata} = '0;
		reset = 1'b1;
		nvm_first_go = 1'b1;
		wdog_active = 1'b1;
		nvm_slot_delay_sel = 4'($random(seed) & 3);
		nvm_empty_slot_delay_sel = 4'($random(seed) & 3);
		hi = 4'(7 + ($random(seed) & 7));
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		chk("step", 32'h0, {28'h0, step_q});
		repeat (8) @(posedge mclk);
		chk("mode", M_PDOWN, mode_q);
		bus(1'b0, OFS_PTR, 32'h0, r);
		chk("ptr", {16'h0, PTR_RST}, r);
		bus(1'b0, OFS_TIME, 32'h0, r);
		chk("time", 32'h22, r);
		bus(1'b0, 8'h40, 32'h0, r);
		chk("unmapped", 32'h0, r);
		bus(1'b1, OFS_PTR, 32'h0642, r);
		bus(1'b1, OFS_REG, 32'h11, r);
		bus(1'b1, OFS_REG + 8'h04, 32'h23, r);
		bus(1'b1, OFS_REG + 8'h08, {27'h0, 1'b1, hi}, r);
		bus(1'b1, OFS_AUX, 32'h5, r);
		trig();
		wait_step(4'h2, 3000);
		repeat (80) @(posedge mclk);
		chk("step", 32'h2, {28'h0, step_q});
		chk("en", {29'h0, on_up(hi, 1, 0, 2), on_up(3, 0, 1, 2), on_up(1, 1, 0, 2)}, {29'h0, reg_en_q[2:0]});
		chk("aux", 32'h0, {31'h0, aux_on_q});
		wsc <= 1'b1;
		wait_step(4'h4, 3000);
		repeat (3) @(posedge mclk);
		chk("mode", M_ACTIVE, mode_q);
		bus(1'b1, OFS_CTRL, 32'h07, r);
		wait_step(4'h6, 3000);
		repeat (80) @(posedge mclk);
		chk("step", 32'h6, {28'h0, step_q});
		chk("irq", 32'h0, {31'h0, irq_out_n});
		chk("en", {29'h0, on_up(hi, 1, 0, 6), on_up(3, 0, 1, 6), on_up(1, 1, 0, 6)}, {29'h0, reg_en_q[2:0]});
		chk("selb", 32'h0, {29'h0, reg_sel_b_q[2:0]});
		chk("aux", 32'h1, {31'h0, aux_on_q});
		bus(1'b1, OFS_STAT, 32'h100, r);
		repeat (2) @(posedge mclk);
		chk("irq", 32'h1, {31'h0, irq_out_n});
		wsc <= 1'b0;
		bus(1'b1, OFS_CTRL, 32'h0, r);
		wait_step(4'h0, 3000);
		repeat (3) @(posedge mclk);
		chk("en", 32'h2, {29'h0, reg_en_q[2:0]});
		chk("selb", 32'h2, {29'h0, reg_sel_b_q[2:0]});
		chk("mode", M_PDOWN, mode_q);
		chk("aux", 32'h0, {31'h0, aux_on_q});
		bus(1'b1, OFS_CTRL, 32'h20, r);
		trig();
		@(posedge mclk);
		chk("reload", 32'h1, {31'h0, partial_nvm_reload});
		nvm_reload_done <= 1'b1;
		@(posedge mclk);
		nvm_reload_done <= 1'b0;
		wait_step(4'h2, 3000);
		chk("reload", 32'h0, {31'h0, partial_nvm_reload});
		@(posedge mclk);
		wdog_timeout <= 1'b1;
		@(posedge mclk);
		wdog_timeout <= 1'b0;
		wait_step(4'h0, 5);
		chk("en", 32'h2, {29'h0, reg_en_q[2:0]});
		bus(1'b1, OFS_CTRL, 32'h10, r);
		chk("mode", M_PDOWN, mode_q);
		shutdown_req <= 1'b1;
		@(posedge mclk);
		shutdown_req <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("mode", M_RESET, mode_q);
		chk("en", 32'h10, {24'h0, reg_en_q});
		repeat (2) @(posedge mclk);
		chk("mode", M_PDOWN, mode_q);
		chk("en", 32'hf8, {24'h0, reg_en_q});
		print_verdict();
	end
endmodule
`default_nettype wire
